// ==== shared/lcr_consts.svh ====
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 25 MHz system clock
// Notes:   definitions only
`ifndef LCR_CONSTS_SVH
`define LCR_CONSTS_SVH

// ***********************************************
// register byte addresses
// ***********************************************
`define LCR_OFS_SER_ADDR   8'h00
`define LCR_OFS_LOC_ADDR   8'h04
`define LCR_OFS_SPREAD     8'h08
`define LCR_OFS_CAL        8'h0C
`define LCR_OFS_LOCK_TOP   8'h7C

// ***********************************************
// field positions
// ***********************************************
`define LCR_ADDR_HI        7
`define LCR_ADDR_LO        1
`define LCR_LOCK_BIT       0
`define LCR_SS_HI          7
`define LCR_SS_LO          6
`define LCR_AUDDIR_BIT     5
`define LCR_AUDEN_BIT      4
`define LCR_PIXEL_CLOCK_RANGE_HI        3
`define LCR_PIXEL_CLOCK_RANGE_LO        2
`define LCR_SERIAL_RATE_RANGE_HI        1
`define LCR_SERIAL_RATE_RANGE_LO        0
`define LCR_RECAL_HI       7
`define LCR_RECAL_LO       6
`define LCR_SAWTOOTH_DIVIDER_HI        4
`define LCR_SAWTOOTH_DIVIDER_LO        0

// ***********************************************
// reset values
// ***********************************************
`define LCR_RST_SS_OFF     2'h0
`define LCR_RST_SS_ON      2'h1
`define LCR_RST_AUDDIR     1'h0
`define LCR_RST_AUDEN      1'h1
`define LCR_RST_PIXEL_CLOCK_RANGE       2'h3
`define LCR_RST_SERIAL_RATE_RANGE       2'h3
`define LCR_RST_RECAL      2'h0
`define LCR_RST_SAWTOOTH_DIVIDER       5'h00
`define LCR_SAWTOOTH_DIVIDER_AUTO      5'h00

// ***********************************************
// recalibration intervals
// ***********************************************
`define LCR_CLK_HZ         25000000
`define LCR_T2_MS          2
`define LCR_T16_MS         16
`define LCR_T256_MS        256
`define LCR_MS_CYC         (`LCR_CLK_HZ / 1000)

`endif

// ==== shared/lcr_pkg.sv ====
// Purpose: types of the link configuration register bank
// Assumes: nothing
// Notes:   constants live in lcr_consts.svh
`default_nettype none
package lcr_pkg;
   typedef enum logic [1:0] {
      LCR_RC_ONCE = 2'b00,
      LCR_RC_2MS  = 2'b01,
      LCR_RC_16MS = 2'b10,
      LCR_RC_256MS = 2'b11
   } lcr_recal_t;

   typedef enum logic [1:0] {
      LCR_SS_NONE = 2'b00,
      LCR_SS_2PCT = 2'b01,
      LCR_SS_NON2 = 2'b10,
      LCR_SS_4PCT = 2'b11
   } lcr_spread_t;
endpackage : lcr_pkg
`default_nettype wire

// ==== hw/lcr_recal_timer.sv ====
// Purpose: pulses a recalibration request at the chosen interval
// Assumes: lock level comes from same clock domain
// Notes:   one pulse at lock, then periodic unless interval is once
`include "lcr_consts.svh"
`default_nettype none
module lcr_recal_timer #(
   parameter int unsigned MS_CYC = `LCR_MS_CYC
) (
   input  wire logic               sys_clk_in,
   input  wire logic               rst_in,
   input  wire logic               clk_en_in,
   input  wire logic               locked_in,
   input  wire lcr_pkg::lcr_recal_t interval_in,
   output logic                    recal_out
);
   import lcr_pkg::*;

   logic [8:0]  ms_lim;
   logic [14:0] cyc_q;
   logic [8:0]  ms_q;
   logic        locked_q;
   logic        ms_tick;
   logic        period_done;
   logic        lock_rise;
   logic        recal_q;

   // ***********************************************
   // interval decode
   // ***********************************************
   assign ms_lim = (interval_in == LCR_RC_2MS)  ? 9'(`LCR_T2_MS)  :
                   (interval_in == LCR_RC_16MS) ? 9'(`LCR_T16_MS) :
                                                  9'(`LCR_T256_MS);
   assign ms_tick     = (cyc_q == 15'(MS_CYC - 1));
   assign period_done = ms_tick && (ms_q == ms_lim - 9'h001);
   assign lock_rise   = locked_in && !locked_q;
   assign recal_out   = recal_q;

   // ***********************************************
   // counters
   // ***********************************************
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         cyc_q    <= 15'h0000;
         ms_q     <= 9'h000;
         locked_q <= 1'b0;
         recal_q  <= 1'b0;
      end else if (clk_en_in) begin
         locked_q <= locked_in;
         recal_q  <= lock_rise || (locked_in && period_done &&
                     interval_in != LCR_RC_ONCE);
         if (!locked_in || lock_rise || period_done) begin
            cyc_q <= 15'h0000;
            ms_q  <= 9'h000;
         end else if (ms_tick) begin
            cyc_q <= 15'h0000;
            ms_q  <= ms_q + 9'h001;
         end else begin
            cyc_q <= cyc_q + 15'h0001;
         end
      end
   end
endmodule : lcr_recal_timer
`default_nettype wire

// ==== hw/lcr_regs.sv ====
// Purpose: link configuration registers 0x00..0x03 on AHB-Lite
// Assumes: single word transfers, one slave, hready from hreadyout
// Notes:   straps are sampled at the first enabled edge after reset
//
// Function
// - hold serializer address in bits 7:1 of 0x00, strap default
// - hold own address in bits 7:1 of 0x01, strap default
// - lock bit 0 of 0x01 makes 0x00..0x1F read only
// - spread select in 0x02 bits 7:6, strap picks 00 or 01
// - audio direction bit 5: 0 device drives clocks, 1 inputs
// - pixel clock range in 0x02 bits 3:2, reset 11 auto
// - serial rate range in 0x02 bits 1:0, reset 11 auto
// - recalibration interval in 0x03 bits 7:6, once or periodic
// - sawtooth divider 0x03 bits 4:0, zero means automatic
//
// Our own choice: the AHB-Lite slave port.
`include "lcr_consts.svh"
`default_nettype none
module lcr_regs #(
   parameter int unsigned MS_CYC = `LCR_MS_CYC
) (
   input  wire logic        sys_clk_in,
   input  wire logic        rst_in,
   input  wire logic        clk_en_in,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // straps and status
   input  wire logic [6:0]  ser_addr_strap_in,
   input  wire logic [6:0]  loc_addr_strap_in,
   input  wire logic        spread_strap_pin_in,
   input  wire logic        link_locked_in,
   input  wire logic        audio_ws_in,
   input  wire logic        audio_sck_in,
   input  wire logic        audio_ws_src_in,
   input  wire logic        audio_sck_src_in,
   // configuration outputs
   output logic [6:0]       remote_serializer_addr_out,
   output logic [6:0]       local_device_addr_out,
   output logic             config_write_lock_out,
   output logic [1:0]       spread_select_out,
   output logic             spread_enable_out,
   output logic             spread_wide_out,
   output logic             audio_clock_direction_out,
   output logic             audio_channel_enable_out,
   output logic [1:0]       pixel_clock_range_out,
   output logic [1:0]       serial_rate_range_out,
   output logic [4:0]       sawtooth_divider_out,
   output logic             sawtooth_auto_out,
   output logic             recal_req_out,
   output logic             audio_ws_out,
   output logic             audio_ws_oe_out,
   output logic             audio_sck_out,
   output logic             audio_sck_oe_out,
   output logic             audio_ws_sync_out,
   output logic             audio_sck_sync_out
);
   import lcr_pkg::*;

   // ***********************************************
   // pin synchronisers
   // ***********************************************
   logic [10:0] sync1_q;
   logic [10:0] sync2_q;
   logic        lock_s;
   logic        ss_strap_s;
   logic [6:0]  ser_strap_s;
   logic        ws_s;
   logic        sck_s;
   logic        strap_done_q;

   // no reset here: straps must already be through both stages at release
   always_ff @(posedge sys_clk_in) begin
      if (clk_en_in) begin
         sync1_q <= {audio_sck_in, audio_ws_in, link_locked_in,
                     spread_strap_pin_in, ser_addr_strap_in};
         sync2_q <= sync1_q;
      end
   end

   assign ser_strap_s = sync2_q[6:0];
   assign ss_strap_s  = sync2_q[7];
   assign lock_s      = sync2_q[8];
   assign ws_s        = sync2_q[9];
   assign sck_s       = sync2_q[10];

   // local address strap through its own two-stage path
   logic [6:0] loc_sync1_q;
   logic [6:0] loc_sync2_q;
   always_ff @(posedge sys_clk_in) begin
      if (clk_en_in) begin
         loc_sync1_q <= loc_addr_strap_in;
         loc_sync2_q <= loc_sync1_q;
      end
   end

   // ***********************************************
   // ahb address phase capture
   // ***********************************************
   logic       wr_pend_q;
   logic       rd_pend_q;
   logic [7:0] addr_q;
   logic       take;
   logic       word_ok;

   assign word_ok   = (hsize == 3'h2) && (haddr[1:0] == 2'h0);
   assign take      = hsel && htrans[1] && hready && word_ok;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         addr_q    <= 8'h00;
      end else if (clk_en_in) begin
         wr_pend_q <= take && hwrite;
         rd_pend_q <= take && !hwrite;
         if (take) begin
            addr_q <= haddr[7:0];
         end
      end
   end

   // ***********************************************
   // register storage
   // ***********************************************
   logic [6:0] ser_addr_q;
   logic [6:0] loc_addr_q;
   logic       lock_q;
   logic [7:0] spread_q;
   logic [7:0] cal_q;
   logic       locked_wr;
   logic       we0;
   logic       we1;
   logic       we2;
   logic       we3;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = (a == o);
   endfunction : hit

   // whole 0x00..0x1F window frozen while locked
   assign locked_wr = lock_q && (addr_q <= `LCR_OFS_LOCK_TOP);
   assign we0 = wr_pend_q && !locked_wr && hit(addr_q, `LCR_OFS_SER_ADDR);
   assign we1 = wr_pend_q && !locked_wr && hit(addr_q, `LCR_OFS_LOC_ADDR);
   assign we2 = wr_pend_q && !locked_wr && hit(addr_q, `LCR_OFS_SPREAD);
   assign we3 = wr_pend_q && !locked_wr && hit(addr_q, `LCR_OFS_CAL);

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         strap_done_q <= 1'b0;
         ser_addr_q   <= 7'h00;
         loc_addr_q   <= 7'h00;
         lock_q       <= 1'b0;
         spread_q     <= {`LCR_RST_SS_OFF, `LCR_RST_AUDDIR,
                          `LCR_RST_AUDEN, `LCR_RST_PIXEL_CLOCK_RANGE,
                          `LCR_RST_SERIAL_RATE_RANGE};
         cal_q        <= {`LCR_RST_RECAL, 1'b0, `LCR_RST_SAWTOOTH_DIVIDER};
      end else if (clk_en_in) begin
         // straps already stand in the second stage at the first edge
         strap_done_q <= 1'b1;
         if (!strap_done_q) begin
            ser_addr_q <= ser_strap_s;
            loc_addr_q <= loc_sync2_q;
            spread_q[`LCR_SS_HI:`LCR_SS_LO] <=
               ss_strap_s ? `LCR_RST_SS_ON : `LCR_RST_SS_OFF;
         end else begin
            if (we0) begin
               ser_addr_q <= hwdata[`LCR_ADDR_HI:`LCR_ADDR_LO];
            end
            if (we1) begin
               loc_addr_q <= hwdata[`LCR_ADDR_HI:`LCR_ADDR_LO];
               lock_q     <= hwdata[`LCR_LOCK_BIT];
            end
            if (we2) begin
               spread_q <= hwdata[7:0];
            end
            if (we3) begin
               cal_q <= {hwdata[7:6], 1'b0, hwdata[4:0]};
            end
         end
      end
   end

   // ***********************************************
   // read data
   // ***********************************************
   logic [7:0] rd_mux;
   assign rd_mux =
      hit(addr_q, `LCR_OFS_SER_ADDR) ? {ser_addr_q, 1'b0} :
      hit(addr_q, `LCR_OFS_LOC_ADDR) ? {loc_addr_q, lock_q} :
      hit(addr_q, `LCR_OFS_SPREAD)   ? spread_q :
      hit(addr_q, `LCR_OFS_CAL)      ? cal_q : 8'h00;
   assign hrdata = rd_pend_q ? {24'h000000, rd_mux} : 32'h00000000;

   // ***********************************************
   // decoded controls
   // ***********************************************
   lcr_spread_t ss_sel;
   assign ss_sel = lcr_spread_t'(spread_q[`LCR_SS_HI:`LCR_SS_LO]);

   assign remote_serializer_addr_out = ser_addr_q;
   assign local_device_addr_out      = loc_addr_q;
   assign config_write_lock_out      = lock_q;
   assign spread_select_out          = spread_q[`LCR_SS_HI:`LCR_SS_LO];
   assign spread_enable_out = (ss_sel == LCR_SS_2PCT) ||
                              (ss_sel == LCR_SS_4PCT);
   assign spread_wide_out   = (ss_sel == LCR_SS_4PCT);
   assign audio_clock_direction_out = spread_q[`LCR_AUDDIR_BIT];
   assign audio_channel_enable_out  = spread_q[`LCR_AUDEN_BIT];
   assign pixel_clock_range_out = spread_q[`LCR_PIXEL_CLOCK_RANGE_HI:`LCR_PIXEL_CLOCK_RANGE_LO];
   assign serial_rate_range_out = spread_q[`LCR_SERIAL_RATE_RANGE_HI:`LCR_SERIAL_RATE_RANGE_LO];
   assign sawtooth_divider_out  = cal_q[`LCR_SAWTOOTH_DIVIDER_HI:`LCR_SAWTOOTH_DIVIDER_LO];
   assign sawtooth_auto_out =
      (cal_q[`LCR_SAWTOOTH_DIVIDER_HI:`LCR_SAWTOOTH_DIVIDER_LO] == `LCR_SAWTOOTH_DIVIDER_AUTO);

   // ***********************************************
   // audio clock pins
   // ***********************************************
   logic ws_q;
   logic sck_q;
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         ws_q  <= 1'b0;
         sck_q <= 1'b0;
      end else if (clk_en_in) begin
         ws_q  <= audio_ws_src_in;
         sck_q <= audio_sck_src_in;
      end
   end
   // direction 0: device sources ws/sck; 1: pins are inputs
   assign audio_ws_oe_out   = !audio_clock_direction_out;
   assign audio_sck_oe_out  = !audio_clock_direction_out;
   assign audio_ws_out      = ws_q;
   assign audio_sck_out     = sck_q;
   assign audio_ws_sync_out  = audio_clock_direction_out & ws_s;
   assign audio_sck_sync_out = audio_clock_direction_out & sck_s;

   // ***********************************************
   // modulation recalibration
   // ***********************************************
   lcr_recal_timer #(
      .MS_CYC      (MS_CYC)
   ) u_recal (
      .sys_clk_in  (sys_clk_in),
      .rst_in      (rst_in),
      .clk_en_in   (clk_en_in),
      .locked_in   (lock_s),
      .interval_in (lcr_recal_t'(cal_q[`LCR_RECAL_HI:`LCR_RECAL_LO])),
      .recal_out   (recal_req_out)
   );
endmodule : lcr_regs
`default_nettype wire

// ==== test/lcr_regs_monitor.sv ====
// Purpose: port assertions for the link configuration registers
// Assumes: one clock, synchronous active high reset
// Notes:   attached by the bind after the module
`default_nettype none
module lcr_regs_monitor (
   input wire logic        sys_clk_in,
   input wire logic        rst_in,
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        config_write_lock_out,
   input wire logic [6:0]  remote_serializer_addr_out,
   input wire logic [6:0]  local_device_addr_out,
   input wire logic [1:0]  spread_select_out,
   input wire logic        spread_enable_out,
   input wire logic        spread_wide_out,
   input wire logic        audio_clock_direction_out,
   input wire logic        audio_ws_oe_out,
   input wire logic        audio_ws_sync_out,
   input wire logic [4:0]  sawtooth_divider_out,
   input wire logic        sawtooth_auto_out,
   input wire logic        recal_req_out
);
   logic rd_q;
   // read data phase follows a taken read
   always_ff @(posedge sys_clk_in) begin
      rd_q <= !rst_in && hsel && htrans[1] && hready && !hwrite;
   end
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   // ***********************************************
   // assertions
   // ***********************************************
   a_read_upper: assert property (
      rd_q |-> hrdata[31:8] == 24'h0) else $error("upper read bits set");
   a_lock_freeze: assert property (
      config_write_lock_out |=> config_write_lock_out
      && $stable(remote_serializer_addr_out)
      && $stable(local_device_addr_out) && $stable(spread_select_out))
      else $error("locked register changed");
   a_spread_on: assert property (
      spread_enable_out == spread_select_out[0]) else $error("spread on");
   a_spread_wide: assert property (
      spread_wide_out == (spread_select_out == 2'h3))
      else $error("spread wide");
   a_audio_drive: assert property (
      audio_ws_oe_out == !audio_clock_direction_out)
      else $error("audio enable wrong");
   a_audio_sync: assert property (
      !audio_clock_direction_out |-> !audio_ws_sync_out)
      else $error("sync while driving");
   a_saw_auto: assert property (
      sawtooth_auto_out == (sawtooth_divider_out == 5'h00))
      else $error("divider auto flag");
   a_recal_pulse: assert property (
      recal_req_out |=> !recal_req_out) else $error("recal too long");
   c_lock: cover property (config_write_lock_out);
   c_recal: cover property (recal_req_out);
   c_read: cover property (rd_q && audio_clock_direction_out);
endmodule : lcr_regs_monitor

bind lcr_regs lcr_regs_monitor u_mon (
   .sys_clk_in(sys_clk_in), .rst_in(rst_in), .hsel(hsel),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
   .config_write_lock_out(config_write_lock_out),
   .remote_serializer_addr_out(remote_serializer_addr_out),
   .local_device_addr_out(local_device_addr_out),
   .spread_select_out(spread_select_out),
   .spread_enable_out(spread_enable_out),
   .spread_wide_out(spread_wide_out),
   .audio_clock_direction_out(audio_clock_direction_out),
   .audio_ws_oe_out(audio_ws_oe_out),
   .audio_ws_sync_out(audio_ws_sync_out),
   .sawtooth_divider_out(sawtooth_divider_out),
   .sawtooth_auto_out(sawtooth_auto_out),
   .recal_req_out(recal_req_out));
`default_nettype wire

// ==== test/lcr_regs_tb.sv ====
// Purpose: self-checking bench for the link configuration registers
// Assumes: 25 MHz clock, hreadyout fed back as hready
// Notes:   one millisecond shortened to 10 cycles
`default_nettype none
module lcr_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import lcr_pkg::*;
   int          num_errors = 0;
   int          checked = 0;
   logic        sys_clk_in, rst_in, clk_en_in, hsel, hwrite, lk, wsp, sckp;
   logic        wss, scks, ssp;
   logic [31:0] haddr, hwdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   wire  [31:0] hrdata;
   wire  [6:0]  ser_o, loc_o;
   wire  [4:0]  sdv;
   wire  [1:0]  ss, prg, srg;
   wire         rdy, lock_o, ss_en, ss_wd, dir, aen, sau, rcl, wso, wsoe;
   wire         scko, sckoe, wsy, scky, hresp;

   lcr_regs #(.MS_CYC(10)) DUT (
      .sys_clk_in(sys_clk_in), .rst_in(rst_in), .clk_en_in(clk_en_in),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(rdy), .hrdata(hrdata),
      .hreadyout(rdy), .hresp(hresp), .ser_addr_strap_in(7'h55),
      .loc_addr_strap_in(7'h2A), .spread_strap_pin_in(ssp),
      .link_locked_in(lk), .audio_ws_in(wsp), .audio_sck_in(sckp),
      .audio_ws_src_in(wss), .audio_sck_src_in(scks),
      .remote_serializer_addr_out(ser_o), .local_device_addr_out(loc_o),
      .config_write_lock_out(lock_o), .spread_select_out(ss),
      .spread_enable_out(ss_en), .spread_wide_out(ss_wd),
      .audio_clock_direction_out(dir), .audio_channel_enable_out(aen),
      .pixel_clock_range_out(prg), .serial_rate_range_out(srg),
      .sawtooth_divider_out(sdv), .sawtooth_auto_out(sau),
      .recal_req_out(rcl), .audio_ws_out(wso), .audio_ws_oe_out(wsoe),
      .audio_sck_out(scko), .audio_sck_oe_out(sckoe),
      .audio_ws_sync_out(wsy), .audio_sck_sync_out(scky));

   // ***********************************************
   // helpers
   // ***********************************************
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : finish_test
   task automatic chk(input string what, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // wait for hready, then take read data at that edge
   task automatic bus_wait;
      int n;
      n = 0;
      @(posedge sys_clk_in);
      while (rdy !== 1'h1 && n < 20) begin
         @(posedge sys_clk_in);
         n++;
      end
      if (n == 20) begin
         num_errors++;
         finish_test();
      end
      rd = hrdata;
   endtask : bus_wait
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      bus_wait();
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      bus_wait();
   endtask : bus
   task automatic rchk(input logic [7:0] a, exp, input string what);
      bus(1'h0, a, 8'h00);
      chk(what, rd, {24'h0, exp});
   endtask : rchk
   task automatic pulse(output int n);
      n = 0;
      do begin
         @(negedge sys_clk_in);
         n++;
      end while (rcl !== 1'h1 && n < 3000);
      if (n == 3000) begin
         num_errors++;
         finish_test();
      end
   endtask : pulse
   task automatic do_reset;
      rst_in <= 1'h1;
      repeat (2) @(posedge sys_clk_in);
      rst_in <= 1'h0;
      repeat (2) @(posedge sys_clk_in);
   endtask : do_reset

   // ***********************************************
   // scenarios
   // ***********************************************
   task automatic t_defaults;
      rchk(8'h00, 8'hAA, "ser addr");
      rchk(8'h04, 8'h54, "loc addr");
      rchk(8'h08, 8'h5F, "spread reg");
      rchk(8'h0C, 8'h00, "cal reg");
      chk("ser out", ser_o, 32'h55);
      chk("loc out", loc_o, 32'h2A);
      chk("ready resp", {rdy, hresp}, 32'h2);
      $display("test defaults done");
   endtask : t_defaults
   task automatic t_fields;
      logic [7:0] v;
      bus(1'h1, 8'h00, 8'hFF);
      rchk(8'h00, 8'hFE, "ser reserved");
      bus(1'h1, 8'h0C, 8'hFF);
      rchk(8'h0C, 8'hDF, "cal reserved");
      chk("divider", {sau, sdv}, 32'h1F);
      for (int i = 0; i < 4; i++) begin
         v = {i[1:0], 2'h1, i[1:0], i[1:0]};
         bus(1'h1, 8'h08, v);
         rchk(8'h08, v, "spread rw");
         chk("ranges", {ss, ss_en, ss_wd, prg, srg},
             {i[1:0], i[0], i == 3, v[3:0]});
         bus(1'h1, 8'h0C, {i[1:0], 6'h00});
         rchk(8'h0C, {i[1:0], 6'h00}, "interval rw");
         chk("auto", sau, 32'h1);
      end
      $display("test fields done");
   endtask : t_fields
   task automatic t_audio;
      bus(1'h1, 8'h08, 8'h1F);
      wss <= 1'h1;
      wsp <= 1'h1;
      sckp <= 1'h1;
      repeat (4) @(posedge sys_clk_in);
      chk("drive", {wsoe, sckoe, wso, scko, wsy, aen}, 32'h39);
      bus(1'h1, 8'h08, 8'h2F);
      repeat (4) @(posedge sys_clk_in);
      chk("input", {wsoe, sckoe, wsy, scky, aen}, 32'h06);
      $display("test audio done");
   endtask : t_audio
   task automatic t_recal;
      int n, c;
      int gap [3] = '{20, 160, 2560};
      for (int i = 1; i < 4; i++) begin
         lk <= 1'h0;
         bus(1'h1, 8'h0C, {i[1:0], 6'h00});
         repeat (4) @(posedge sys_clk_in);
         lk <= 1'h1;
         pulse(n);
         pulse(n);
         pulse(n);
         chk("recal gap", n, gap[i - 1]);
         @(posedge sys_clk_in);
      end
      lk <= 1'h0;
      bus(1'h1, 8'h0C, 8'h00);
      repeat (4) @(posedge sys_clk_in);
      lk <= 1'h1;
      c = 0;
      repeat (300) begin
         @(negedge sys_clk_in);
         c += rcl;
      end
      chk("once pulses", c, 32'h1);
      @(posedge sys_clk_in);
      $display("test recal done");
   endtask : t_recal
   task automatic t_lock;
      bus(1'h1, 8'h04, 8'h55);
      @(posedge sys_clk_in);
      chk("lock out", lock_o, 32'h1);
      bus(1'h1, 8'h00, 8'h10);
      bus(1'h1, 8'h04, 8'h00);
      rchk(8'h00, 8'hFE, "locked ser");
      rchk(8'h04, 8'h55, "unlock refused");
      rchk(8'h40, 8'h00, "unmapped");
      ssp <= 1'h0;
      do_reset();
      rchk(8'h04, 8'h54, "lock cleared");
      rchk(8'h00, 8'hAA, "ser reload");
      rchk(8'h08, 8'h1F, "strap low");
      rchk(8'h0C, 8'h00, "cal reset");
      $display("test lock done");
   endtask : t_lock

   initial begin
      sys_clk_in = 1'h0;
      forever #20 sys_clk_in = ~sys_clk_in;
   end
   initial begin
      {rst_in, clk_en_in, hsel, ssp} = 4'hF;
      {hwrite, lk, wsp, sckp, wss, scks} = 6'h00;
      {haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, 3'h2};
      repeat (2) @(posedge sys_clk_in);
      rst_in <= 1'h0;
      repeat (2) @(posedge sys_clk_in);
      t_defaults();
      t_fields();
      t_audio();
      t_recal();
      t_lock();
      finish_test();
   end
endmodule : lcr_regs_tb
`default_nettype wire
